//--- pkg/pwrsv_pkg.sv
// Constants and types for the power-save mode controller
package pwrsv_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] PWR_CONTROL_OFS = 8'h87;
    localparam logic [7:0] IRQ_EXT_CONTROL_OFS = 8'hc0;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int IDLE_REQUEST_BIT = 0;
    localparam int POWERDOWN_REQUEST_BIT = 1;
    localparam int PWR_RESERVED_BIT = 5;
    localparam int IRQ_TWO_TRIGGER_TYPE = 0;
    localparam int IRQ_TWO_FLAG = 1;
    localparam int IRQ_TWO_ENABLE = 2;
    localparam int IRQ_TWO_POLARITY = 3;
    localparam int IRQ_THREE_TRIGGER_TYPE = 4;
    localparam int IRQ_THREE_FLAG = 5;
    localparam int IRQ_THREE_ENABLE = 6;
    localparam int IRQ_THREE_POLARITY = 7;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] PWR_CONTROL_RST = 8'h00;
    localparam logic [7:0] IRQ_EXT_CONTROL_RST = 8'h00;
    localparam int STARTUP_CYCLES_DEF = 1024;
    localparam int STARTUP_W = 16;
    localparam logic [1:0] RAM_BLOCK_CYCLES = 2'h2;
    localparam int PORT_W = 8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_IDLE = 3'h1,
        ST_PDOWN = 3'h2,
        ST_WARMUP = 3'h3,
        ST_RSTHOLD = 3'h4
    } pwrsv_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pwrsv_bus_t;

    typedef struct packed {
        logic irqZero;
        logic irqZeroEn;
        logic irqZeroEdge;
        logic irqOne;
        logic irqOneEn;
        logic irqOneEdge;
        logic irqTwo;
        logic irqThree;
        logic keypadWake;
        logic usbWake;
        logic anyIrq;
    } pwrsv_wake_t;

    typedef struct packed {
        pwrsv_state_t st;
        logic [7:0] pwrCtl;
        logic [7:0] irqCtl;
        logic [1:0] pinPrev;
        logic rstPrev;
        logic fromReset;
        logic [STARTUP_W-1:0] cnt;
        logic [1:0] ramBlk;
        logic [PORT_W-1:0] portHeld;
        logic [7:0] rdata;
        logic serve;
    } pwrsv_regs_t;

endpackage : pwrsv_pkg

//--- design/pwrsv_power_save.sv
// Power-save mode controller: idle, power-down, wake-up and start-up
`timescale 1ns/10ps
// What this block does
// - Idle request stops CPU clock; all CPU state is kept.
// - During idle port outputs hold the levels present at idle entry.
// - Peripheral clocks keep running in idle.
// - Enabled interrupt or reset ends idle; interrupt is serviced at once.
// - Power-down request stops oscillator and flash power.
// - RAM contents kept through power-down; SFRs need not be.
// - Power-down exits only on reset or enabled ext, keypad, USB irq.
// - Irq zero and one wake only if enabled and low/falling type.
// - Irq two and three wake when enabled with any trigger setting.
// - Irq wake restarts oscillator, holds clock until counter full.
// - Reset pin rise in power-down wakes; run starts after pin low.
// - Reset ending idle blocks RAM access for two machine cycles.
// - Power-down bit clears by CPU write or by any wake event.
// - Idle bit clears by CPU write or by any idle exit.
// - Power control register at 87h: bit 1 power-down, bit 0 idle.
// - Irq two/three have polarity bit and edge/level type bit.
module pwrsv_power_save #(
    parameter int STARTUP_CYCLES = pwrsv_pkg::STARTUP_CYCLES_DEF
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire pwrsv_pkg::pwrsv_bus_t bus,
    output logic [7:0] rdData,
    input wire logic extRstPin,
    input wire pwrsv_pkg::pwrsv_wake_t wake,
    input wire logic [pwrsv_pkg::PORT_W-1:0] portDrive,
    output logic [pwrsv_pkg::PORT_W-1:0] portPins,
    output logic cpuClkEn,
    output logic periphClkEn,
    output logic oscEn,
    output logic flashPowerOn,
    output logic ramRetain,
    output logic ramAccessBlock,
    output logic wakeServe,
    output logic coreRunning
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pwrsv_pkg::pwrsv_regs_t s_r;
    pwrsv_pkg::pwrsv_regs_t s_nxt;

    logic wrPwr;
    logic wrIrq;
    logic rstRise;
    logic [1:0] irqHit;
    logic pdWake;
    logic idleWake;
    logic cntFull;

    localparam logic [pwrsv_pkg::STARTUP_W-1:0] CNT_LAST =
        pwrsv_pkg::STARTUP_W'(STARTUP_CYCLES - 1);

    // ------------------------------------------------------------
    // Wake detection
    // ------------------------------------------------------------
    assign wrPwr = bus.wr && (bus.addr == pwrsv_pkg::PWR_CONTROL_OFS);
    assign wrIrq = bus.wr && (bus.addr == pwrsv_pkg::IRQ_EXT_CONTROL_OFS);
    assign rstRise = extRstPin && !s_r.rstPrev;
    assign cntFull = (s_r.cnt == CNT_LAST);

    // Per-line trigger: level compares with polarity, edge needs a change
    for (genvar i = 0; i < 2; i++) begin : g_ext
        localparam int BASE = 4 * i;
        logic pin;
        logic pol;
        logic typ;
        assign pin = (i == 0) ? wake.irqTwo : wake.irqThree;
        assign pol = s_r.irqCtl[BASE + pwrsv_pkg::IRQ_TWO_POLARITY];
        assign typ = s_r.irqCtl[BASE + pwrsv_pkg::IRQ_TWO_TRIGGER_TYPE];
        assign irqHit[i] = typ ? ((pin == pol) && (s_r.pinPrev[i] != pol))
                               : (pin == pol);
    end

    // Only low/falling type on lines zero and one; zero/one edge bits
    // report falling-edge mode, level mode means low level
    always_comb begin
        pdWake = (wake.irqZeroEn && !wake.irqZero)
            || (wake.irqOneEn && !wake.irqOne)
            || (s_r.irqCtl[pwrsv_pkg::IRQ_TWO_ENABLE] && irqHit[0])
            || (s_r.irqCtl[pwrsv_pkg::IRQ_THREE_ENABLE] && irqHit[1])
            || wake.keypadWake || wake.usbWake;
        idleWake = wake.anyIrq || pdWake;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.rstPrev = extRstPin;
        s_nxt.pinPrev = {wake.irqThree, wake.irqTwo};
        s_nxt.serve = 1'b0;
        s_nxt.rdata = 8'h00;
        if (s_r.ramBlk != 2'h0) begin
            s_nxt.ramBlk = s_r.ramBlk - 2'h1;
        end
        // Hardware flags set after software clear so an event is kept
        if (wrIrq) begin
            s_nxt.irqCtl = bus.wdata;
        end
        if (irqHit[0]) begin
            s_nxt.irqCtl[pwrsv_pkg::IRQ_TWO_FLAG] = 1'b1;
        end
        if (irqHit[1]) begin
            s_nxt.irqCtl[pwrsv_pkg::IRQ_THREE_FLAG] = 1'b1;
        end
        if (bus.rd) begin
            case (bus.addr)
                pwrsv_pkg::PWR_CONTROL_OFS: s_nxt.rdata = s_r.pwrCtl;
                pwrsv_pkg::IRQ_EXT_CONTROL_OFS: s_nxt.rdata = s_r.irqCtl;
                default: s_nxt.rdata = 8'h00;
            endcase
        end
        case (s_r.st)
            pwrsv_pkg::ST_RUN: begin
                // Port follows the core while it runs
                s_nxt.portHeld = portDrive;
                if (wrPwr) begin
                    s_nxt.pwrCtl = bus.wdata;
                    s_nxt.pwrCtl[pwrsv_pkg::PWR_RESERVED_BIT] = 1'b0;
                    if (bus.wdata[pwrsv_pkg::POWERDOWN_REQUEST_BIT]) begin
                        s_nxt.pwrCtl[pwrsv_pkg::IDLE_REQUEST_BIT] = 1'b0;
                        s_nxt.st = pwrsv_pkg::ST_PDOWN;
                    end else if (bus.wdata[pwrsv_pkg::IDLE_REQUEST_BIT]) begin
                        s_nxt.st = pwrsv_pkg::ST_IDLE;
                    end
                end
            end
            pwrsv_pkg::ST_IDLE: begin
                // Port stays frozen: core clock is gated, no new drive
                if (rstRise) begin
                    s_nxt.pwrCtl[pwrsv_pkg::IDLE_REQUEST_BIT] = 1'b0;
                    s_nxt.ramBlk = pwrsv_pkg::RAM_BLOCK_CYCLES;
                    s_nxt.st = pwrsv_pkg::ST_RUN;
                end else if (idleWake) begin
                    s_nxt.pwrCtl[pwrsv_pkg::IDLE_REQUEST_BIT] = 1'b0;
                    s_nxt.serve = 1'b1;
                    s_nxt.st = pwrsv_pkg::ST_RUN;
                end
            end
            pwrsv_pkg::ST_PDOWN: begin
                if (rstRise || pdWake) begin
                    s_nxt.pwrCtl[pwrsv_pkg::POWERDOWN_REQUEST_BIT] = 1'b0;
                    s_nxt.fromReset = rstRise;
                    s_nxt.cnt = '0;
                    s_nxt.st = pwrsv_pkg::ST_WARMUP;
                end
            end
            pwrsv_pkg::ST_WARMUP: begin
                s_nxt.cnt = s_r.cnt + 1'b1;
                if (cntFull) begin
                    s_nxt.cnt = '0;
                    if (s_r.fromReset) begin
                        s_nxt.st = pwrsv_pkg::ST_RSTHOLD;
                    end else begin
                        s_nxt.serve = 1'b1;
                        s_nxt.st = pwrsv_pkg::ST_RUN;
                    end
                end
            end
            pwrsv_pkg::ST_RSTHOLD: begin
                // Pin normally outlasts the count; leave once it drops
                if (!extRstPin) begin
                    s_nxt.st = pwrsv_pkg::ST_RUN;
                end
            end
            default: begin
                s_nxt.st = pwrsv_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_r.st <= pwrsv_pkg::ST_RUN;
            s_r.pwrCtl <= pwrsv_pkg::PWR_CONTROL_RST;
            s_r.irqCtl <= pwrsv_pkg::IRQ_EXT_CONTROL_RST;
            s_r.pinPrev <= 2'h0;
            s_r.rstPrev <= 1'b0;
            s_r.fromReset <= 1'b0;
            s_r.cnt <= '0;
            s_r.ramBlk <= 2'h0;
            s_r.portHeld <= '0;
            s_r.rdata <= 8'h00;
            s_r.serve <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdData = s_r.rdata;
    assign portPins = s_r.portHeld;
    assign cpuClkEn = (s_r.st == pwrsv_pkg::ST_RUN);
    assign coreRunning = cpuClkEn;
    assign periphClkEn = (s_r.st == pwrsv_pkg::ST_RUN)
        || (s_r.st == pwrsv_pkg::ST_IDLE);
    assign oscEn = (s_r.st != pwrsv_pkg::ST_PDOWN);
    assign flashPowerOn = (s_r.st != pwrsv_pkg::ST_PDOWN);
    // RAM kept in every mode; other registers may be lost at low supply
    assign ramRetain = 1'b1;
    assign ramAccessBlock = (s_r.ramBlk != 2'h0);
    assign wakeServe = s_r.serve;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence pdEnter;
        s_r.st == pwrsv_pkg::ST_PDOWN;
    endsequence

    sequence warmRun;
        s_r.st == pwrsv_pkg::ST_WARMUP && !cpuClkEn;
    endsequence

    chk_idle_gates_cpu: assert property (
        s_r.st == pwrsv_pkg::ST_RUN && wrPwr
        && bus.wdata[1:0] == 2'h1 |=> !cpuClkEn && periphClkEn)
        else $error("idle entry did not gate only the cpu clock");

    chk_idle_port_hold: assert property (
        s_r.st == pwrsv_pkg::ST_IDLE |=> $stable(portPins))
        else $error("port pins changed during idle");

    chk_idle_irq_serve: assert property (
        s_r.st == pwrsv_pkg::ST_IDLE && !rstRise && idleWake
        |=> wakeServe && cpuClkEn
        && !s_r.pwrCtl[pwrsv_pkg::IDLE_REQUEST_BIT])
        else $error("idle exit on interrupt not serviced");

    chk_pd_stops_osc: assert property (
        pdEnter |-> !oscEn && !flashPowerOn && !periphClkEn)
        else $error("oscillator or flash active in power-down");

    chk_pd_only_wake: assert property (
        pdEnter and (!rstRise && !pdWake) |=> pdEnter)
        else $error("power-down left without a wake source");

    chk_irq_one_pol: assert property (
        pdEnter and (wake.irqOneEn && !wake.irqOne) |=> warmRun)
        else $error("enabled low irq one did not wake");

    chk_warm_len: assert property (
        pdEnter and (pdWake && !rstRise) |=> warmRun[*8])
        else $error("clock released before start-up count");

    chk_reset_hold: assert property (
        s_r.st == pwrsv_pkg::ST_RSTHOLD && extRstPin |=> !cpuClkEn)
        else $error("execution began while reset pin high");

    chk_ram_block: assert property (
        s_r.st == pwrsv_pkg::ST_IDLE && rstRise
        |=> ramAccessBlock[*2] ##1 !ramAccessBlock)
        else $error("ram block not two cycles on idle reset exit");

    chk_pd_precedence: assert property (
        s_r.st == pwrsv_pkg::ST_RUN && wrPwr && bus.wdata[1:0] == 2'h3
        |=> pdEnter and (!s_r.pwrCtl[pwrsv_pkg::IDLE_REQUEST_BIT]))
        else $error("idle taken over power-down");

    chk_pd_bit_clear: assert property (
        s_r.st == pwrsv_pkg::ST_WARMUP
        |-> !s_r.pwrCtl[pwrsv_pkg::POWERDOWN_REQUEST_BIT])
        else $error("power-down bit kept after wake");

endmodule : pwrsv_power_save

//--- tb/pwrsv_wake_model.sv
// Wake-source model: external irq pins, keypad, USB, pending irq
`timescale 1ns/10ps
module pwrsv_wake_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic fire,
    input wire logic [2:0] sel,
    input wire logic [1:0] en01,
    input wire logic wakeServe,
    output pwrsv_pkg::pwrsv_wake_t wake
);
    // ------------------------------------------------------------
    // Quiet levels: all four irq pins idle high, inactive after reset
    // ------------------------------------------------------------
    pwrsv_pkg::pwrsv_wake_t quiet;
    always_comb begin
        quiet = '0;
        quiet.irqZero = 1'b1;
        quiet.irqOne = 1'b1;
        quiet.irqTwo = 1'b1;
        quiet.irqThree = 1'b1;
    end
    // Service routine drops its own source, so no retrigger
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wake <= quiet;
        end else if (wakeServe || (fire && sel == 3'h7)) begin
            wake <= quiet;
        end else if (fire) begin
            case (sel)
                3'h0: wake.irqZero <= 1'b0;
                3'h1: wake.irqOne <= 1'b0;
                3'h2: wake.irqTwo <= 1'b0;
                3'h3: wake.irqThree <= 1'b0;
                3'h4: wake.keypadWake <= 1'b1;
                3'h5: wake.usbWake <= 1'b1;
                default: wake.anyIrq <= 1'b1;
            endcase
        end
        if (!rst) begin
            wake.irqZeroEn <= en01[0];
            wake.irqOneEn <= en01[1];
        end
    end
endmodule : pwrsv_wake_model

//--- tb/tb_top.sv
// Self-checking bench for the power-save mode controller
`timescale 1ns/10ps
module tb_top;
    localparam int STARTUP = 12;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    pwrsv_pkg::pwrsv_bus_t bus = '0;
    pwrsv_pkg::pwrsv_wake_t wake;
    logic [7:0] rdData;
    logic extRstPin = 1'b0;
    logic [7:0] portDrive = 8'h00;
    logic [7:0] portPins;
    logic cpuClkEn;
    logic periphClkEn;
    logic oscEn;
    logic flashPowerOn;
    logic ramRetain;
    logic ramAccessBlock;
    logic wakeServe;
    logic coreRunning;
    logic fire = 1'b0;
    logic [2:0] sel = 3'h0;
    logic [1:0] en01 = 2'h0;
    int fails = 0;
    int checks_done = 0;
    logic [7:0] v;
    int n;
    pwrsv_power_save #(.STARTUP_CYCLES(STARTUP)) u_dut (
        .clk_sys(clk_sys), .rst(rst), .bus(bus), .rdData(rdData),
        .extRstPin(extRstPin), .wake(wake), .portDrive(portDrive),
        .portPins(portPins), .cpuClkEn(cpuClkEn),
        .periphClkEn(periphClkEn), .oscEn(oscEn),
        .flashPowerOn(flashPowerOn), .ramRetain(ramRetain),
        .ramAccessBlock(ramAccessBlock), .wakeServe(wakeServe),
        .coreRunning(coreRunning));
    pwrsv_wake_model u_src (
        .clk_sys(clk_sys), .rst(rst), .fire(fire), .sel(sel),
        .en01(en01), .wakeServe(wakeServe), .wake(wake));
    always #4 clk_sys = ~clk_sys;
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1;
        d = rdData;
    endtask : rd
    task automatic fire_src(input logic [2:0] s);
        @(posedge clk_sys);
        sel <= s;
        fire <= 1'b1;
        @(posedge clk_sys);
        fire <= 1'b0;
    endtask : fire_src
    task automatic wait_run(output int k);
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
            #1;
        end while (cpuClkEn !== 1'b1 && k < 200);
    endtask : wait_run
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        rd(8'h87, v);
        chk("pwr reset", v, 8'h00);
        rd(8'hc0, v);
        chk("irq reset", v, 8'h00);
        wr(8'h87, 8'h3c);
        rd(8'h87, v);
        chk("pwr readback", v, 8'h1c);
        wr(8'h87, 8'h00);
        wr(8'hc0, 8'h99);
        rd(8'hc0, v);
        chk("irq polarity type", v, 8'h99);
        wr(8'hc0, 8'h00);
        rd(8'h55, v);
        chk("unmapped read", v, 8'h00);
        $display("test regs done");
    endtask : t_regs
    task automatic t_idle;
        portDrive <= 8'ha5;
        wr(8'h87, 8'h01);
        chk("idle cpu clk", cpuClkEn, 1'b0);
        chk("idle periph clk", periphClkEn, 1'b1);
        chk("idle osc", oscEn, 1'b1);
        portDrive <= 8'h5a;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("idle port hold", portPins, 8'ha5);
        fire_src(3'h6);
        wait_run(n);
        chk("idle exit", 8'(n), 8'h01);
        chk("idle serve", wakeServe, 1'b1);
        rd(8'h87, v);
        chk("idle bit clear", v, 8'h00);
        chk("port follows", portPins, 8'h5a);
        $display("test idle done");
    endtask : t_idle
    task automatic t_pd_src(input logic [2:0] s, input logic [7:0] c,
                            input logic [1:0] e);
        repeat (500) @(posedge clk_sys); // 4 us gap
        en01 <= e;
        wr(8'hc0, c);
        wr(8'h87, 8'h02); // bus stays idle after
        chk("pd osc", oscEn, 1'b0);
        chk("pd flash", flashPowerOn, 1'b0);
        chk("pd cpu clk", coreRunning, 1'b0);
        chk("pd ram", ramRetain, 1'b1);
        fire_src(s);
        wait_run(n);
        chk("warm-up length", 8'(n), 8'(STARTUP + 1));
        chk("pd serve", wakeServe, 1'b1);
        rd(8'h87, v);
        chk("pd bit clear", v, 8'h00);
        wr(8'hc0, 8'h00);
        en01 <= 2'h0;
        $display("test pd source %0d done", s);
    endtask : t_pd_src
    task automatic t_pd_reset;
        repeat (500) @(posedge clk_sys); // 4 us gap
        wr(8'h87, 8'h02);
        fire_src(3'h0);
        repeat (20) @(posedge clk_sys);
        #1;
        chk("disabled irq zero", oscEn, 1'b0);
        fire_src(3'h7);
        extRstPin <= 1'b1;
        repeat (STARTUP + 6) @(posedge clk_sys); // held past count
        #1;
        chk("rst hold cpu", cpuClkEn, 1'b0);
        chk("rst hold osc", oscEn, 1'b1);
        extRstPin <= 1'b0;
        wait_run(n);
        chk("rst release", 8'(n <= 3), 8'h01);
        chk("rst no serve", wakeServe, 1'b0);
        rd(8'h87, v);
        chk("rst pd clear", v, 8'h00);
        $display("test pd reset done");
    endtask : t_pd_reset
    task automatic t_idle_reset;
        wr(8'h87, 8'h01); // no port write follows
        extRstPin <= 1'b1;
        n = 0;
        repeat (8) begin
            @(posedge clk_sys);
            #1;
            n += int'(ramAccessBlock === 1'b1);
        end
        chk("ram block cycles", 8'(n), 8'h02);
        chk("reset ends idle", cpuClkEn, 1'b1);
        extRstPin <= 1'b0;
        rd(8'h87, v);
        chk("idle clear by rst", v, 8'h00);
        $display("test idle reset done");
    endtask : t_idle_reset
    task automatic t_both;
        repeat (500) @(posedge clk_sys); // 4 us gap
        wr(8'h87, 8'h03);
        chk("both osc", oscEn, 1'b0);
        chk("both periph", periphClkEn, 1'b0);
        rd(8'h87, v);
        chk("both stored", v, 8'h02);
        fire_src(3'h5);
        wait_run(n);
        chk("both wake", 8'(n), 8'(STARTUP + 1));
        $display("test both bits done");
    endtask : t_both
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_idle();
        t_pd_src(3'h0, 8'h00, 2'h1);
        t_pd_src(3'h1, 8'h00, 2'h2);
        t_pd_src(3'h2, 8'h04, 2'h0);
        t_pd_src(3'h3, 8'h50, 2'h0);
        t_pd_src(3'h4, 8'h00, 2'h0);
        t_pd_src(3'h5, 8'h00, 2'h0);
        t_pd_reset();
        t_idle_reset();
        t_both();
        report_and_stop();
    end
    // Normal run is near 34 us; a hang is cut well beyond that
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end
endmodule : tb_top
